// ### include/mws_pins_regs.vh
// Constants for the multi-width serial pin front end.
// Assumes inclusion by bare name from the design file; definitions only.
`ifndef MWS_PINS_REGS_VH
`define MWS_PINS_REGS_VH

// ***************************************************************
// Lane width codes
// ***************************************************************
`define WIDTH_SINGLE   2'h0
`define WIDTH_DUAL     2'h1
`define WIDTH_QUAD     2'h2

// ***************************************************************
// Byte framing
// ***************************************************************
`define INSTR_BITS     4'h8
`define BYTE_BITS      4'h8

// ***************************************************************
// Synchroniser depth and reset value of the lane outputs
// ***************************************************************
`define SYNC_STAGES    2
`define LANES_RESET    4'h0
// Synchroniser reset: lanes high as pulled, select high, clock low, reset pin low
`define SYNC_RESET     7'h7C

`endif

// ### rtl/multi_width_serial_pin_interface.v
// Pin-level front end of a serial memory: samples select, clock and four lanes,
// assembles received bytes and shifts out transmit bytes one, two or four bits
// per serial clock. Assumes a command decoder beside it that supplies the width
// of each phase and the quad enable bit, and a tri-state pad ring that turns
// each output / output-enable pair into a pin.
//
// Operation
// - Hardware reset pin low returns to standby
// - All traffic moves serially over lane pins
// - Single, dual and quad widths supported
// - Lane 0 input, bidirectional in wide commands
// - Lane 1 output, bidirectional in wide commands
// - Lane 2 write protect unless quad enabled
// - Lane 3 pause input unless quad operation
// - Sample on rising, drive on falling edge
// - Select high ignores inputs except write protect, outputs float
// - Quad enable bit selects lanes 2, 3 data
`include "mws_pins_regs.vh"

module multi_width_serial_pin_interface (
   input  wire       clock_i,
   input  wire       rstn_i,
   input  wire       hw_reset_n_i,
   input  wire       sck_i,
   input  wire       cs_n_i,
   input  wire [3:0] lane_i,
   output reg  [3:0] lane_o,
   output reg  [3:0] lane_oe_n_o,
   input  wire       quad_enable_bit_i,
   input  wire [1:0] rx_width_i,
   input  wire [1:0] tx_width_i,
   input  wire       tx_active_i,
   input  wire       tx_load_i,
   input  wire [7:0] tx_data_i,
   output reg        tx_empty_o,
   output reg  [7:0] rx_data_o,
   output reg        rx_valid_o,
   output reg        rx_instr_o,
   output reg        selected_o,
   output reg        paused_o,
   output reg        write_protect_n_o,
   output reg        standby_o
);

   // ***************************************************************
   // Helpers
   // ***************************************************************

   // Bits moved per serial clock edge for a width code
   function [3:0] step_of;
      input [1:0] width;
      input       quad_en;
      begin
         case (width)
            `WIDTH_DUAL: step_of = 4'h2;
            `WIDTH_QUAD: step_of = quad_en ? 4'h4 : 4'h2;
            default:     step_of = 4'h1;
         endcase
      end
   endfunction

   // ***************************************************************
   // Pin synchronisers
   // ***************************************************************
   reg  [6:0] sync1_reg;
   reg  [6:0] sync2_reg;
   reg        sck_prev_reg;

   // Two stages on every pin; only the second stage feeds logic.
   // Reset values match the idle levels of clock, select and lanes so no false edge follows reset.
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         sync1_reg    <= `SYNC_RESET;
         sync2_reg    <= `SYNC_RESET;
         sck_prev_reg <= 1'b0;
      end else begin
         sync1_reg    <= {lane_i, cs_n_i, sck_i, hw_reset_n_i};
         sync2_reg    <= sync1_reg;
         sck_prev_reg <= sync2_reg[1];
      end
   end

   wire       hwrst_n_s = sync2_reg[0];
   wire       sck_s     = sync2_reg[1];
   wire       cs_n_s    = sync2_reg[2];
   wire [3:0] lane_s    = sync2_reg[6:3];
   wire       sck_rise  = sck_s & ~sck_prev_reg;
   wire       sck_fall  = ~sck_s & sck_prev_reg;

   // ***************************************************************
   // Lane roles
   // ***************************************************************

   // Lanes 2 and 3 carry data only when the quad enable bit is set
   wire       quad_mode = quad_enable_bit_i;
   // Pause pin only counts outside quad operation
   wire       hold_req  = ~quad_mode & ~lane_s[3] & ~cs_n_s;
   // Clean frame: select low, no hardware reset
   wire       frame_on  = ~cs_n_s & hwrst_n_s;
   wire [3:0] rx_step   = step_of(rx_width_i, quad_mode);
   wire [3:0] tx_step   = step_of(tx_width_i, quad_mode);

   // ***************************************************************
   // Control state
   // ***************************************************************
   reg  [7:0] rx_shift_reg;
   reg  [3:0] rx_count_reg;
   reg        instr_done_reg;
   reg  [7:0] tx_shift_reg;
   reg  [3:0] tx_count_reg;
   reg        hold_reg;

   // Hold starts only while the serial clock is low; it ends then or when the frame closes
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         hold_reg <= 1'b0;
      end else if (!frame_on) begin
         hold_reg <= 1'b0;
      end else if (!sck_s) begin
         hold_reg <= hold_req;
      end
   end

   wire active = frame_on & ~hold_reg;

   // Receive: sample lanes on the rising serial clock edge
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         rx_shift_reg   <= 8'h00;
         rx_count_reg   <= 4'h0;
         instr_done_reg <= 1'b0;
         rx_data_o      <= 8'h00;
         rx_valid_o     <= 1'b0;
         rx_instr_o     <= 1'b0;
      end else begin
         rx_valid_o <= 1'b0;
         if (!frame_on) begin
            // Deselect or reset pin abandons any partial byte
            rx_count_reg   <= 4'h0;
            instr_done_reg <= 1'b0;
         end else if (active && sck_rise) begin
            if (!instr_done_reg) begin
               // Instruction always arrives one bit per clock on lane 0
               rx_shift_reg <= {rx_shift_reg[6:0], lane_s[0]};
               if (rx_count_reg == `INSTR_BITS - 4'h1) begin
                  rx_count_reg   <= 4'h0;
                  instr_done_reg <= 1'b1;
                  rx_data_o      <= {rx_shift_reg[6:0], lane_s[0]};
                  rx_valid_o     <= 1'b1;
                  rx_instr_o     <= 1'b1;
               end else begin
                  rx_count_reg <= rx_count_reg + 4'h1;
               end
            end else begin
               case (rx_step)
                  4'h4: rx_shift_reg <= {rx_shift_reg[3:0], lane_s};
                  4'h2: rx_shift_reg <= {rx_shift_reg[5:0], lane_s[1:0]};
                  default: rx_shift_reg <= {rx_shift_reg[6:0], lane_s[0]};
               endcase
               if (rx_count_reg + rx_step >= `BYTE_BITS) begin
                  rx_count_reg <= 4'h0;
                  rx_valid_o   <= 1'b1;
                  rx_instr_o   <= 1'b0;
                  case (rx_step)
                     4'h4: rx_data_o <= {rx_shift_reg[3:0], lane_s};
                     4'h2: rx_data_o <= {rx_shift_reg[5:0], lane_s[1:0]};
                     default: rx_data_o <= {rx_shift_reg[6:0], lane_s[0]};
                  endcase
               end else begin
                  rx_count_reg <= rx_count_reg + rx_step;
               end
            end
         end
      end
   end

   // Transmit: new bits appear on the falling serial clock edge
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         tx_shift_reg <= 8'h00;
         tx_count_reg <= 4'h0;
         tx_empty_o   <= 1'b1;
         lane_o       <= `LANES_RESET;
      end else if (!frame_on) begin
         tx_count_reg <= 4'h0;
         tx_empty_o   <= 1'b1;
      end else if (tx_load_i) begin
         // A load while a byte is still going out replaces it
         tx_shift_reg <= tx_data_i;
         tx_count_reg <= `BYTE_BITS;
         tx_empty_o   <= 1'b0;
      end else if (active && sck_fall && tx_active_i && tx_count_reg != 4'h0) begin
         case (tx_step)
            4'h4: begin
               lane_o       <= tx_shift_reg[7:4];
               tx_shift_reg <= {tx_shift_reg[3:0], 4'h0};
            end
            4'h2: begin
               lane_o       <= {2'h0, tx_shift_reg[7:6]};
               tx_shift_reg <= {tx_shift_reg[5:0], 2'h0};
            end
            default: begin
               lane_o       <= {2'h0, tx_shift_reg[7], 1'b0};
               tx_shift_reg <= {tx_shift_reg[6:0], 1'b0};
            end
         endcase
         if (tx_count_reg <= tx_step) begin
            tx_count_reg <= 4'h0;
            tx_empty_o   <= 1'b1;
         end else begin
            tx_count_reg <= tx_count_reg - tx_step;
         end
      end
   end

   // ***************************************************************
   // Output enables and status
   // ***************************************************************
   reg [3:0] oe_n_next;

   // Drive only the lanes the current width owns; float the rest
   always @* begin
      oe_n_next = 4'hF;
      if (active && tx_active_i) begin
         case (tx_step)
            4'h4:    oe_n_next = 4'h0;
            4'h2:    oe_n_next = 4'hC;
            default: oe_n_next = 4'hD;
         endcase
      end
   end

   // Registered status; write protect reads high in quad mode
   always @(posedge clock_i or negedge rstn_i) begin
      if (!rstn_i) begin
         lane_oe_n_o       <= 4'hF;
         selected_o        <= 1'b0;
         paused_o          <= 1'b0;
         write_protect_n_o <= 1'b1;
         standby_o         <= 1'b1;
      end else begin
         lane_oe_n_o       <= oe_n_next;
         selected_o        <= frame_on;
         paused_o          <= hold_reg;
         write_protect_n_o <= quad_mode | lane_s[2];
         standby_o         <= ~frame_on;
      end
   end

endmodule // multi_width_serial_pin_interface

// ### test/mws_pins_asserts.sv
// Checker for the multi-width serial pin front end.
// Assumes it is bound into the design and sees only the design's ports.
module mws_pins_asserts (
   input wire logic       clock_i,
   input wire logic       rstn_i,
   input wire logic       hw_reset_n_i,
   input wire logic       quad_enable_bit_i,
   input wire logic [1:0] tx_width_i,
   input wire logic [3:0] lane_oe_n_o,
   input wire logic       tx_empty_o,
   input wire logic       rx_valid_o,
   input wire logic       rx_instr_o,
   input wire logic       selected_o,
   input wire logic       paused_o,
   input wire logic       write_protect_n_o,
   input wire logic       standby_o
);
   timeunit 1ns;
   timeprecision 100ps;
   // ************
   // Properties
   // ************
   default clocking @(posedge clock_i); endclocking
   default disable iff (!rstn_i);
   // One cycle of slack in the $past terms covers the registered outputs
   AST_STANDBY: assert property (standby_o == !selected_o)
      else $error("standby is not the inverse of selected");
   AST_HW_RESET: assert property (!hw_reset_n_i [*5] |-> !selected_o && standby_o)
      else $error("reset pin low did not return to standby");
   AST_DESEL_FLOAT: assert property (!selected_o [*2] |-> lane_oe_n_o == 4'hF)
      else $error("lane driven while deselected");
   AST_DESEL_NO_RX: assert property (!selected_o [*5] |-> !rx_valid_o)
      else $error("byte received while deselected");
   AST_SINGLE_OE: assert property (tx_width_i == 2'h0 && $past(tx_width_i) == 2'h0
      |-> lane_oe_n_o[0] && lane_oe_n_o[3:2] == 2'h3)
      else $error("single width drove a lane other than lane 1");
   AST_NO_QUAD: assert property (!quad_enable_bit_i && !$past(quad_enable_bit_i)
      |-> lane_oe_n_o[3:2] == 2'h3)
      else $error("lanes 2 or 3 driven without quad enable");
   AST_WP_QUAD: assert property (quad_enable_bit_i && $past(quad_enable_bit_i) |-> write_protect_n_o)
      else $error("write protect active in quad mode");
   AST_RX_PULSE: assert property (rx_valid_o |=> !rx_valid_o)
      else $error("receive pulse longer than one cycle");
   AST_INSTR: assert property ($rose(rx_instr_o) |-> rx_valid_o)
      else $error("instruction flag without byte pulse");
   AST_PAUSE: assert property (paused_o [*5] |-> !rx_valid_o)
      else $error("byte received while paused");
   COV_INSTR: cover property (rx_valid_o && rx_instr_o);
   COV_TX: cover property (!tx_empty_o);
   COV_PAUSE: cover property (paused_o);
endmodule // mws_pins_asserts

bind multi_width_serial_pin_interface mws_pins_asserts mws_pins_asserts_inst (
   .clock_i, .rstn_i, .hw_reset_n_i, .quad_enable_bit_i, .tx_width_i, .lane_oe_n_o,
   .tx_empty_o, .rx_valid_o, .rx_instr_o, .selected_o, .paused_o, .write_protect_n_o,
   .standby_o
);

// ### test/mws_host_model.sv
// Host controller model: select, serial clock and lane drivers.
// Assumes the bench wires pin_o to the design's lane inputs.
module mws_host_model (
   input  wire logic [3:0] dev_lane_i,
   input  wire logic [3:0] dev_oe_n_i,
   output logic            sck_o,
   output logic            cs_n_o,
   output logic [3:0]      pin_o
);
   timeunit 1ns;
   timeprecision 100ps;
   logic [3:0] en = 4'h0;
   logic [3:0] v = 4'h0;
   initial begin
      sck_o = 1'b0;
      cs_n_o = 1'b1;
   end
   // Lanes 2, 3 have pull-ups; released 0, 1 show the inverse, not a stale level
   always_comb
      for (int k = 0; k < 4; k++)
         pin_o[k] = !dev_oe_n_i[k] ? dev_lane_i[k] : en[k] ? v[k] : (k > 1) | ~v[k];
   // Open or close a frame; the clock is parked low outside frames
   task automatic frame(input bit on);
      #40 sck_o = 1'b0;
      cs_n_o = !on;
      #40;
   endtask
   // Drive lanes 3:2 low (pause, write protect) or release them
   task automatic pull(input logic [1:0] low);
      en[3:2] = low;
      v[3:2] = 2'h0;
   endtask
   // One byte MSB first, w bits per clock; lanes change at the falling edge
   task automatic xfer(input logic [7:0] b, input int w, input bit drv, output logic [7:0] r);
      r = 8'h00;
      for (int i = 8 - w; i >= 0; i -= w) begin
         sck_o = 1'b0;
         if (w == 4) en = {4{drv}};
         else en[1:0] = {drv & (w > 1), drv};
         v = w == 1 ? {v[3:1], b[i]} : 4'(b >> i);
         #32 sck_o = 1'b1;
         r = (r << w) | 8'(w == 1 ? {3'h0, pin_o[1]} : pin_o & 4'((1 << w) - 1));
         #32;
      end
   endtask
endmodule // mws_host_model

// ### test/test_multi_width_serial_pin_interface.sv
// Self-checking bench for the multi-width serial pin front end.
// Assumes the host model and the bound checker are compiled alongside.
module test_multi_width_serial_pin_interface;
   timeunit 1ns;
   timeprecision 100ps;
   logic clock_i, rstn_i, hw_reset_n_i, quad_enable_bit_i;
   logic tx_active_i, tx_load_i;
   logic [1:0] rx_width_i, tx_width_i;
   logic [7:0] tx_data_i, r;
   wire logic sck, cs_n, tx_empty_o, rx_valid_o, rx_instr_o, selected_o, paused_o, wp_n, standby_o;
   wire logic [3:0] pin, lane_o, lane_oe_n_o;
   wire logic [7:0] rx_data_o;
   logic [8:0] rxq[$];
   int num_errors = 0;
   int checked = 0;
   // ************
   // Harness
   // ************
   initial begin
      clock_i = 1'b0;
      forever #2.5 clock_i = ~clock_i;
   end
   multi_width_serial_pin_interface multi_width_serial_pin_interface_inst (.clock_i, .rstn_i,
      .hw_reset_n_i, .sck_i(sck), .cs_n_i(cs_n), .lane_i(pin), .lane_o, .lane_oe_n_o,
      .quad_enable_bit_i, .rx_width_i, .tx_width_i, .tx_active_i, .tx_load_i, .tx_data_i,
      .tx_empty_o, .rx_data_o, .rx_valid_o, .rx_instr_o, .selected_o, .paused_o,
      .write_protect_n_o(wp_n), .standby_o);
   mws_host_model mws_host_model_inst (.dev_lane_i(lane_o), .dev_oe_n_i(lane_oe_n_o),
      .sck_o(sck), .cs_n_o(cs_n), .pin_o(pin));
   // Received bytes are queued with their instruction flag
   always @(posedge clock_i) if (rx_valid_o === 1'b1) rxq.push_back({rx_instr_o, rx_data_o});
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      checked++;
      if (seen !== exp) begin
         num_errors++;
         $display("BAD %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic rx_is(input logic [8:0] e);
      check(rxq.size() ? 16'(rxq.pop_front()) : 16'hFFFF, 16'(e));
   endtask
   task automatic mode(input logic q, input logic [1:0] rw);
      @(posedge clock_i);
      quad_enable_bit_i <= q;
      rx_width_i <= rw;
   endtask
   // Instruction, one byte in, one byte out at width w
   task automatic xchg(input logic q, input logic [1:0] code, input int w,
                       input logic [7:0] ib, input logic [7:0] ob);
      mode(q, code);
      mws_host_model_inst.frame(1'b1);
      mws_host_model_inst.xfer(8'hA5, 1, 1'b1, r);
      rx_is({1'b1, 8'hA5});
      mws_host_model_inst.xfer(ib, w, 1'b1, r);
      rx_is({1'b0, ib});
      @(posedge clock_i);
      tx_data_i <= ob;
      tx_width_i <= code;
      tx_active_i <= 1'b1;
      tx_load_i <= 1'b1;
      @(posedge clock_i);
      tx_load_i <= 1'b0;
      mws_host_model_inst.xfer(8'h00, w, 1'b0, r);
      check(r, ob);
      check(tx_empty_o, 1'b1);
      @(posedge clock_i);
      tx_active_i <= 1'b0;
      mws_host_model_inst.frame(1'b0);
      // The device keeps sampling while it talks; those bytes carry nothing
      rxq.delete();
   endtask
   task automatic t_single; xchg(1'b0, 2'h0, 1, 8'h3C, 8'hC3); endtask
   // Dual, then quad code without quad enable, which must fall back to dual
   task automatic t_dual;
      xchg(1'b0, 2'h1, 2, 8'h69, 8'h96);
      xchg(1'b0, 2'h2, 2, 8'hB4, 8'h4B);
   endtask
   task automatic t_quad;
      xchg(1'b1, 2'h2, 4, 8'h5A, 8'hE1);
      check(wp_n, 1'b1);
      mode(1'b0, 2'h0);
   endtask
   // Pause and write protect driven low mid-frame; clocks must be ignored
   task automatic t_pins;
      mws_host_model_inst.frame(1'b1);
      mws_host_model_inst.pull(2'h3);
      repeat (8) @(posedge clock_i);
      check({paused_o, wp_n}, 2'h2);
      mws_host_model_inst.xfer(8'hFF, 1, 1'b1, r);
      check(rxq.size(), 0);
      mws_host_model_inst.frame(1'b0);
      mws_host_model_inst.pull(2'h0);
      repeat (8) @(posedge clock_i);
      check({paused_o, wp_n}, 2'h1);
   endtask
   // Reset pin mid-frame, then clocks while deselected, then a fresh command
   task automatic t_reset;
      mws_host_model_inst.frame(1'b1);
      mws_host_model_inst.xfer(8'hA5, 1, 1'b1, r);
      rx_is({1'b1, 8'hA5});
      @(posedge clock_i);
      hw_reset_n_i <= 1'b0;
      repeat (6) @(posedge clock_i);
      check({selected_o, standby_o, lane_oe_n_o}, 6'h1F);
      mws_host_model_inst.xfer(8'h11, 1, 1'b1, r);
      mws_host_model_inst.frame(1'b0);
      @(posedge clock_i);
      hw_reset_n_i <= 1'b1;
      mws_host_model_inst.xfer(8'h22, 1, 1'b1, r);
      check(rxq.size(), 0);
      mws_host_model_inst.frame(1'b0);
      mws_host_model_inst.frame(1'b1);
      mws_host_model_inst.xfer(8'hA5, 1, 1'b1, r);
      rx_is({1'b1, 8'hA5});
      mws_host_model_inst.frame(1'b0);
   endtask
   task automatic results;
      $display("Comparisons %0d, mismatches %0d", checked, num_errors);
      if (num_errors == 0 && checked > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask
   initial begin
      rstn_i <= 1'b0;
      hw_reset_n_i <= 1'b1;
      quad_enable_bit_i <= 1'b0;
      tx_active_i <= 1'b0;
      tx_load_i <= 1'b0;
      rx_width_i <= 2'h0;
      tx_width_i <= 2'h0;
      tx_data_i <= 8'h00;
      repeat (12) @(posedge clock_i);
      rstn_i <= 1'b1;
      repeat (4) @(posedge clock_i);
      t_single;
      t_dual;
      t_quad;
      t_pins;
      t_reset;
      results;
   end
   // Watchdog: the sequence needs about 8.4 us
   initial begin
      #100000;
      num_errors++;
      results;
   end
endmodule // test_multi_width_serial_pin_interface
